/* src/cbls_pkg.sv */
// constants, types and lane helpers for the byte-lane steering bus unit
// Operation
// - even bytes low lane, odd bytes high lane
// - bank word address on upper lines
// - even byte: low lane, upper enable high
// - odd byte: high lane, upper enable low
// - data states repeat address-phase upper enable level
// - high-lane byte lands in low half
// - even word: one cycle, both banks
// - odd word: two cycles, address incremented
// - byte read floats all sixteen lines
// - byte write drives all sixteen lines
// - I/O space steered like memory space
// - read strobe only after address latched
// - drive buffer enable and direction
// - bus cycle at least four T states
package cbls_pkg;
    localparam int         C_ADDR_W     = 20;
    localparam int         C_DATA_W     = 16;
    localparam int         C_FIFO_DEPTH = 8;
    // T3 stretched so read data clears the pin synchroniser before T4
    localparam int         C_T3_CYCLES  = 3;
    localparam logic [1:0] C_T3_LAST    = 2'(C_T3_CYCLES - 1);
    localparam logic [3:0] C_TOP_STATUS = 4'h0;
    localparam logic [7:0] C_ZERO_BYTE  = 8'h00;

    typedef struct packed {
        logic [C_ADDR_W-1:0] addr;
        logic                word;
        logic                write;
        logic                io;
        logic [C_DATA_W-1:0] wdata;
    } cbls_req_t;

    localparam int C_REQ_W = $bits(cbls_req_t);

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_T2, S_T3, S_T4} cbls_tstate_t;

    // upper lane enable level for one bus cycle
    function automatic logic cbls_ule_n(input logic word, input logic bit0, input logic second);
        return second | (~word & ~bit0);
    endfunction

    function automatic logic cbls_data_phase(input cbls_tstate_t st);
        return (st == S_T2) || (st == S_T3) || (st == S_T4);
    endfunction

    // write lanes; the idle lane repeats the byte, receivers ignore it
    function automatic logic [C_DATA_W-1:0] cbls_lanes(input cbls_req_t r, input logic second);
        logic [C_DATA_W-1:0] v;
        v = r.wdata;
        if (!r.word) begin
            v = {r.wdata[7:0], r.wdata[7:0]};
        end else if (r.addr[0] && !second) begin
            v = {r.wdata[7:0], r.wdata[7:0]};
        end else if (r.addr[0]) begin
            v = {r.wdata[15:8], r.wdata[15:8]};
        end
        return v;
    endfunction
endpackage

/* src/cbls_stream_if.sv */
// valid/ready word stream between the request queue and the bus sequencer
interface cbls_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* src/cbls_fifo.sv */
// request queue with registered read data
module cbls_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic  i_clk,   // system clock
    input  wire logic  i_rstn,  // async reset, active low
    cbls_stream_if.snk s_in,    // filling side
    cbls_stream_if.src s_out    // draining side
);
    localparam int CW = $clog2(D + 1);
    localparam int PW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic          full;
        logic          ov;
        logic [W-1:0]  od;
    } cbls_fifo_st_t;

    cbls_fifo_st_t q;
    cbls_fifo_st_t d;
    logic [W-1:0]  mem_q [D];
    logic          push;
    logic          pop;

    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    always_comb begin
        d    = q;
        push = s_in.valid && !q.full;
        pop  = (q.cnt != '0) && (!q.ov || s_out.ready);
        if (pop) begin
            d.od = mem_q[q.rp];
            d.rp = q.rp + 1'b1;
        end
        d.ov = pop || (q.ov && !s_out.ready);
        if (push) begin
            d.wp = q.wp + 1'b1;
        end
        d.cnt  = q.cnt + CW'(push) - CW'(pop);
        d.full = (d.cnt == CW'(D));
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // storage needs no reset; only pointers and flags do
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[q.wp] <= s_in.data;
        end
    end

    assign s_in.ready  = !q.full;
    assign s_out.valid = q.ov;
    assign s_out.data  = q.od;
endmodule

/* src/cbls_bus_unit.sv */
// byte-lane steering and multiplexed bus sequencer
module cbls_bus_unit
    import cbls_pkg::*;
#(
    parameter int FIFO_DEPTH = C_FIFO_DEPTH
) (
    input  wire logic                i_clk,                        // 100 MHz clock
    input  wire logic                i_rstn,                       // async reset
    input  wire logic                i_req_valid,                  // request offered
    input  wire logic [C_ADDR_W-1:0] i_req_addr,                   // byte address
    input  wire logic                i_req_word,                   // 1 word, 0 byte
    input  wire logic                i_req_write,                  // 1 write, 0 read
    input  wire logic                i_req_io,                     // 1 I/O space
    input  wire logic [C_DATA_W-1:0] i_req_wdata,                  // write data, byte low
    output logic                     o_req_ready,                  // queue has room
    output logic                     o_rsp_valid,                  // read data pulse
    output logic [C_DATA_W-1:0]      o_rsp_data,                   // read data
    input  wire logic [C_DATA_W-1:0] i_ad,                         // bus pins in
    output logic [C_DATA_W-1:0]      o_ad,                         // bus pins out
    output logic                     o_ad_oe_n,                    // low while driving
    output logic [3:0]               o_top_multiplexed_address,    // top bits / status
    output logic                     o_upper_lane_enable_n,        // upper lane select
    output logic                     o_addr_latch,                 // address latch strobe
    output logic                     o_rd_n,                       // read strobe
    output logic                     o_wr_n,                       // write strobe
    output logic                     o_mem_io,                     // 1 memory, 0 I/O
    output logic                     o_data_buffer_enable,         // transceiver enable
    output logic                     o_transmit_receive_direction  // 1 transmit
);
    typedef struct packed {
        cbls_tstate_t        st;
        logic [1:0]          t3cnt;
        logic                second;
        cbls_req_t           cur;
        logic [7:0]          lo;
        logic [C_DATA_W-1:0] ad_s1;
        logic [C_DATA_W-1:0] ad_s2;
        logic                ale;
        logic                rd_n;
        logic                wr_n;
        logic                ule_n;
        logic [3:0]          top;
        logic [C_DATA_W-1:0] ad;
        logic                ad_oe_n;
        logic                buf_en;
        logic                tx_dir;
        logic                mio;
        logic                rsp_v;
        logic [C_DATA_W-1:0] rsp_d;
    } cbls_top_st_t;

    localparam cbls_top_st_t C_RST = '{
        st:      S_IDLE,
        rd_n:    1'b1,
        wr_n:    1'b1,
        ule_n:   1'b1,
        ad_oe_n: 1'b1,
        default: '0
    };

    cbls_top_st_t q;
    cbls_top_st_t d;

    cbls_stream_if #(.W(C_REQ_W)) in_if ();
    cbls_stream_if #(.W(C_REQ_W)) out_if ();

    logic                take;
    logic                odd_word;
    logic [C_ADDR_W-1:0] ea;
    logic [C_DATA_W-1:0] smp;

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("request queue needs at least two entries");
    end

    assign in_if.valid = i_req_valid;
    assign in_if.data  = cbls_req_t'{addr: i_req_addr, word: i_req_word, write: i_req_write,
                                     io: i_req_io, wdata: i_req_wdata};
    assign o_req_ready = in_if.ready;

    // a new request is pulled only between bus cycles
    assign out_if.ready = (q.st == S_IDLE);

    cbls_fifo #(
        .W (C_REQ_W),
        .D (FIFO_DEPTH)
    ) u_queue (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .s_in   (in_if),
        .s_out  (out_if)
    );

    always_comb begin
        d        = q;
        d.ad_s1  = i_ad;
        d.ad_s2  = q.ad_s1;
        d.rsp_v  = 1'b0;
        take     = (q.st == S_IDLE) && out_if.valid;
        odd_word = q.cur.word && q.cur.addr[0];
        smp      = q.ad_s2;

        unique case (q.st)
            S_IDLE: begin
                if (take) begin
                    d.cur    = out_if.data;
                    d.second = 1'b0;
                    d.st     = S_ADDR;
                end
            end
            S_ADDR: begin
                d.st = S_T2;
            end
            S_T2: begin
                d.st    = S_T3;
                d.t3cnt = '0;
            end
            S_T3: begin
                if (q.t3cnt == C_T3_LAST) begin
                    d.st = S_T4;
                end else begin
                    d.t3cnt = q.t3cnt + 1'b1;
                end
            end
            S_T4: begin
                if (!q.cur.write) begin
                    if (odd_word && !q.second) begin
                        d.lo = smp[15:8];
                    end else begin
                        d.rsp_v = 1'b1;
                        if (!q.cur.word) begin
                            // odd byte moves down to the low half
                            d.rsp_d = {C_ZERO_BYTE, q.cur.addr[0] ? smp[15:8] : smp[7:0]};
                        end else if (q.cur.addr[0]) begin
                            d.rsp_d = {smp[7:0], q.lo};
                        end else begin
                            d.rsp_d = smp;
                        end
                    end
                end
                if (odd_word && !q.second) begin
                    d.second = 1'b1;
                    d.st     = S_ADDR;
                end else begin
                    d.st = S_IDLE;
                end
            end
        endcase

        // pin levels for the state being entered
        ea    = d.cur.addr + C_ADDR_W'(d.second);
        d.ale = (d.st == S_ADDR);
        d.top = d.ale ? ea[19:16] : C_TOP_STATUS;
        if (d.ale) begin
            d.ad      = ea[C_DATA_W-1:0];
            d.ad_oe_n = 1'b0;
            // lane choice from bit zero
            d.ule_n   = cbls_ule_n(d.cur.word, ea[0], d.second);
            d.tx_dir  = d.cur.write;
            d.mio     = !d.cur.io;
        end else if (cbls_data_phase(d.st) && d.cur.write) begin
            d.ad      = cbls_lanes(d.cur, d.second);
            d.ad_oe_n = 1'b0;
        end else begin
            d.ad_oe_n = 1'b1;
        end
        // strobes open in T2, once the latch strobe has fallen
        d.rd_n = !(!d.cur.write && (d.st == S_T2 || d.st == S_T3));
        d.wr_n = !(d.cur.write && (d.st == S_T2 || d.st == S_T3));
        d.buf_en = cbls_data_phase(d.st);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= C_RST;
        end else begin
            q <= d;
        end
    end

    assign o_rsp_valid                  = q.rsp_v;
    assign o_rsp_data                   = q.rsp_d;
    assign o_ad                         = q.ad;
    assign o_ad_oe_n                    = q.ad_oe_n;
    assign o_top_multiplexed_address    = q.top;
    // ule_n is held through the data states, so the status copy equals it
    assign o_upper_lane_enable_n        = q.ule_n;
    assign o_addr_latch                 = q.ale;
    assign o_rd_n                       = q.rd_n;
    assign o_wr_n                       = q.wr_n;
    assign o_mem_io                     = q.mio;
    assign o_data_buffer_enable         = q.buf_en;
    assign o_transmit_receive_direction = q.tx_dir;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    AST_RD_AFTER_LATCH: assert property ($fell(q.rd_n) |-> $past(q.ale) && !q.ale)
        else $error("read strobe without a preceding latch strobe");

    AST_MIN_CYCLE: assert property (
        q.st == S_ADDR |=> q.st == S_T2 ##1 (q.st == S_T3) [*3] ##1 q.st == S_T4)
        else $error("bus cycle shorter than planned");

    AST_STATUS_COPY: assert property (
        q.st == S_ADDR |=> (q.ule_n == $past(q.ule_n)) [*5])
        else $error("upper lane status differs from address phase level");

    AST_READ_FLOAT: assert property (
        cbls_data_phase(q.st) && !q.cur.write |-> q.ad_oe_n)
        else $error("bus driven during a read data phase");

    AST_WRITE_DRIVE: assert property (
        cbls_data_phase(q.st) && q.cur.write
        |-> !q.ad_oe_n && (q.st == S_T2 || $stable(q.ad)))
        else $error("write lanes not driven steadily");

    AST_BYTE_LANE: assert property (
        q.ale && !q.cur.word |-> q.ule_n == !q.ad[0] && q.ad[0] == q.cur.addr[0])
        else $error("byte lane select mismatched to bit zero");

    AST_EVEN_WORD: assert property (
        q.st == S_T4 && q.cur.word && !q.cur.addr[0] |=> q.st == S_IDLE)
        else $error("even word took more than one bus cycle");

    AST_ODD_WORD: assert property (
        q.st == S_T4 && q.cur.word && q.cur.addr[0] && !q.second
        |=> q.st == S_ADDR && q.ule_n && !q.ad[0] && q.second)
        else $error("odd word second cycle not steered to low lane");

    AST_BUF_ISOLATE: assert property (
        q.ale |-> !q.buf_en ##1 q.buf_en && q.tx_dir == q.cur.write)
        else $error("buffer enabled in address phase or wrong direction");
endmodule

/* tb/cbls_mem_model.sv */
// behavioural even and odd bank pair on the multiplexed bus
module cbls_mem_model (
    input  wire logic        i_clk,   // bus clock
    input  wire logic [15:0] i_ad,    // unit pin value
    input  wire logic        i_oe_n,  // unit drives when low
    input  wire logic [3:0]  i_top,   // top address bits in T1
    input  wire logic        i_ule_n, // odd bank select, low active
    input  wire logic        i_ale,   // address latch strobe
    input  wire logic        i_rd_n,  // read strobe
    input  wire logic        i_wr_n,  // write strobe
    output logic      [15:0] o_pins   // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [logic [19:0]];
    logic [19:0] adr_q;
    logic        ule_n_q;
    logic [15:0] last_q = 16'h0000;

    // unwritten bytes read back a fill derived from their address
    function automatic logic [7:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : a[7:0];
    endfunction

    // address and lane select held for the cycle
    always @(posedge i_clk) begin
        if (i_ale) begin
            adr_q <= {i_top, i_ad};
            ule_n_q <= i_ule_n;
        end
        last_q <= o_pins;
    end

    // drivers opened by the read strobe only; released lines drift
    always @* begin
        o_pins = ~last_q;
        if (!i_oe_n) begin
            o_pins = i_ad;
        end else if (!i_rd_n) begin
            if (!adr_q[0]) begin
                o_pins[7:0] = rd({adr_q[19:1], 1'h0});
            end
            if (!ule_n_q) begin
                o_pins[15:8] = rd({adr_q[19:1], 1'h1});
            end
        end
    end

    // each bank takes its own lane only when enabled
    always @(posedge i_clk) begin
        if (!i_wr_n && !i_oe_n) begin
            if (!adr_q[0]) begin
                mem[{adr_q[19:1], 1'h0}] = i_ad[7:0];
            end
            if (!ule_n_q) begin
                mem[{adr_q[19:1], 1'h1}] = i_ad[15:8];
            end
        end
    end
endmodule

/* tb/cpu_bus_byte_lane_steering_bench.sv */
// self-checking bench for the byte-lane steering bus unit
module cpu_bus_byte_lane_steering_bench
    import cbls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [C_ADDR_W-1:0] a;
        logic                ule_n;
        logic                mio;
        logic                dir;
    } cbls_cyc_t;
    logic                i_clk = 1'h0, i_rstn = 1'h0, i_req_valid = 1'h0;
    logic                i_req_word = 1'h0, i_req_write = 1'h0, i_req_io = 1'h0;
    logic [C_ADDR_W-1:0] i_req_addr = 20'h0_0000;
    logic [C_DATA_W-1:0] i_req_wdata = 16'h0000, i_ad, o_ad, o_rsp_data;
    logic                o_req_ready, o_rsp_valid, o_ad_oe_n, o_addr_latch, o_rd_n, o_wr_n;
    logic                o_upper_lane_enable_n, o_mem_io, o_data_buffer_enable;
    logic                o_transmit_receive_direction;
    logic [3:0]          o_top_multiplexed_address;
    logic [31:0]         seed = 32'h0000_0022, r, q;
    logic [15:0]         wa [4] = '{16'h1000, 16'h1003, 16'h2000, 16'h2001};
    logic [7:0]          shadow [logic [19:0]];
    logic [15:0]         exp_rsp [$];
    cbls_cyc_t           exp_cyc [$];
    logic                ule_addr, started = 1'h0, full_seen = 1'h0;
    int                  n_fail = 0, comparisons = 0, cyc_n = 9, p;

    cbls_bus_unit #(.FIFO_DEPTH(C_FIFO_DEPTH)) dut (
        .i_clk, .i_rstn, .i_req_valid, .i_req_addr, .i_req_word, .i_req_write, .i_req_io,
        .i_req_wdata, .o_req_ready, .o_rsp_valid, .o_rsp_data, .i_ad, .o_ad, .o_ad_oe_n,
        .o_top_multiplexed_address, .o_upper_lane_enable_n, .o_addr_latch, .o_rd_n, .o_wr_n,
        .o_mem_io, .o_data_buffer_enable, .o_transmit_receive_direction
    );
    cbls_mem_model bank (
        .i_clk, .i_ad(o_ad), .i_oe_n(o_ad_oe_n), .i_top(o_top_multiplexed_address),
        .i_ule_n(o_upper_lane_enable_n), .i_ale(o_addr_latch), .i_rd_n(o_rd_n),
        .i_wr_n(o_wr_n), .o_pins(i_ad)
    );

    always #5 i_clk = ~i_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] sh(input logic [19:0] a);
        return shadow.exists(a) ? shadow[a] : a[7:0];
    endfunction

    // expected bus cycles and read data, worked out at the moment of take
    task automatic note(input logic [19:0] a, input logic w, wr, io, input logic [15:0] d);
        logic [19:0] b;
        b = a + 20'h0_0001;
        exp_cyc.push_back('{a, !w & !a[0], !io, wr}); // lanes
        if (w && a[0]) begin
            exp_cyc.push_back('{b, 1'h1, !io, wr}); // second half
        end
        if (wr) begin
            shadow[a] = d[7:0];
            if (w) begin
                shadow[b] = d[15:8];
            end
        end else begin
            exp_rsp.push_back(w ? {sh(b), sh(a)} : {8'h00, sh(a)}); // low half
        end
    endtask

    // entered at a falling edge; request held until the edge that takes it
    task automatic req(input logic [19:0] a, input logic w, wr, io, input logic [15:0] d);
        i_req_valid = 1'h1;
        i_req_addr = a;
        i_req_word = w;
        i_req_write = wr;
        i_req_io = io;
        i_req_wdata = d;
        while (o_req_ready !== 1'h1) @(negedge i_clk);
        note(a, w, wr, io, d);
        @(negedge i_clk);
    endtask

    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'h1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic cmp_rsp(input logic [15:0] got);
        chk(exp_rsp.size() != 0 && got === exp_rsp[0], "read data");
        if (exp_rsp.size() != 0) begin
            void'(exp_rsp.pop_front());
        end
    endtask

    task automatic cmp_cyc(input cbls_cyc_t got);
        chk(exp_cyc.size() != 0 && got === exp_cyc[0], "bus cycle address phase");
        if (exp_cyc.size() != 0) begin
            void'(exp_cyc.pop_front());
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // outputs looked at mid-cycle, where every register has settled
    always @(negedge i_clk) begin
        if (i_rstn) begin
            cyc_n++;
            if (o_rsp_valid === 1'h1) begin
                cmp_rsp(o_rsp_data); // data
            end
            if (o_addr_latch === 1'h1) begin
                cmp_cyc({o_top_multiplexed_address, o_ad, o_upper_lane_enable_n, o_mem_io,
                         o_transmit_receive_direction});
                chk(o_rd_n & o_wr_n & !o_data_buffer_enable & !o_ad_oe_n, "address phase");
                chk(cyc_n >= 4, "short bus cycle"); // length
                cyc_n = 0;
                ule_addr = o_upper_lane_enable_n;
            end
            if (o_data_buffer_enable === 1'h1) begin
                chk(o_upper_lane_enable_n === ule_addr, "lane status"); // status copy
                chk(o_top_multiplexed_address === C_TOP_STATUS, "top status");
            end
            if (o_rd_n === 1'h0) begin
                chk(o_ad_oe_n & !o_transmit_receive_direction, "read"); // float
            end
            if (o_wr_n === 1'h0) begin
                chk(!o_ad_oe_n & o_transmit_receive_direction, "write"); // drive
            end
            if (started && o_req_ready === 1'h0) begin
                full_seen = 1'h1;
            end
        end
    end

    initial begin
        repeat (4) @(negedge i_clk);
        i_rstn = 1'h1;
        repeat (2) @(negedge i_clk);
        started = 1'h1;
        // every transfer kind, memory then I/O space, read back on both lanes
        for (int s = 0; s < 2; s++) begin
            for (int j = 0; j < 20; j++) begin
                r = xs();
                p = j / 4;
                req({4'(s), wa[j % 4]} + 20'(p == 2) - 20'(p == 4),
                    p == 0 ? j % 4 < 2 : p > 2, p == 0, s[0], r[15:0]);
            end
        end
        $display("test directed done");
        // back-to-back random traffic over a small window fills the queue
        for (int j = 0; j < 60; j++) begin
            r = xs();
            q = xs();
            req({r[19:16], 12'h0a0, r[3:0]}, r[20], r[21], r[22], q[15:0]);
        end
        i_req_valid = 1'h0;
        for (int k = 0; k < 3000 && exp_rsp.size() + exp_cyc.size() != 0; k++) begin
            @(negedge i_clk);
        end
        repeat (10) @(negedge i_clk);
        chk(full_seen, "queue never refused"); // full queue refuses
        chk(exp_rsp.size() + exp_cyc.size() == 0, "results missing");
        $display("test random done");
        end_of_test();
    end

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
endmodule
